// *** inc/swc_pkg.sv ***
package swc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PRG_T_US      = 512;
  localparam int unsigned SPU_T_MS      = 524;
  localparam int unsigned PRG_CYC       = PRG_T_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SPU_CYC       = SPU_T_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned OTHER_CYC     = 1000;

  // ----------------------------------------------------------------
  // host byte codes and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_TERM      = 8'hF1;
  localparam logic [7:0] CMD_DATA_MODE = 8'hE1;
  localparam logic [7:0] CMD_CMD_MODE  = 8'hE3;
  localparam logic [7:0] CMD_RESET     = 8'hC1;
  localparam logic [7:0] CMD_READ      = 8'hFF;
  localparam logic [2:0] SB_TAG        = 3'h4;
  localparam logic [2:0] PULSE_TAG     = 3'h7;
  localparam logic [1:0] PULSE_SUB     = 2'h3;
  localparam logic [5:0] RSP_RESET_HI  = 6'h33;
  localparam logic [3:0] RSP_PULSE_LO  = 4'hC;
  localparam int unsigned BIT_SPU      = 1;
  localparam int unsigned BIT_VAL      = 4;
  localparam logic [2:0] PAR_PRG       = 3'h2;
  localparam logic [2:0] PAR_SPU       = 3'h3;
  localparam logic [2:0] DUR_INF       = 3'h7;
  localparam logic [2:0] DUR_DOC       = 3'h4;
  localparam logic [2:0] DUR_RST       = 3'h4;
  localparam logic [1:0] PRES_OK       = 2'h1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SWC_ST_IDLE = 3'b000,
    SWC_ST_RST  = 3'b001,
    SWC_ST_BIT  = 3'b010,
    SWC_ST_BYTE = 3'b011,
    SWC_ST_PTIM = 3'b100,
    SWC_ST_PINF = 3'b101,
    SWC_ST_PRSP = 3'b110
  } swc_state_type;

  typedef enum logic [1:0] {
    SWC_OP_RESET = 2'b00,
    SWC_OP_BIT   = 2'b01,
    SWC_OP_BYTE  = 2'b10
  } swc_op_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } swc_byte_type;

  typedef struct packed {
    logic       valid;
    swc_op_type op;
    logic [7:0] data;
  } swc_bus_req_type;

  typedef struct packed {
    logic       done;
    logic [7:0] data;
    logic [1:0] pres;
  } swc_bus_rsp_type;

  typedef struct packed {
    swc_state_type   st;
    logic            buf_full;
    logic [7:0]      buf_data;
    logic [7:0]      cmd;
    logic            data_mode;
    logic            armed;
    logic [2:0]      prg_code;
    logic [2:0]      spu_code;
    logic            pulse_on;
    logic            pulse_prg;
    logic [31:0]     timer;
    swc_byte_type    tx;
    swc_bus_req_type bus;
    logic            ovr;
  } swc_regs_type;

endpackage

// *** rtl/swc_cmd.sv ***
`timescale 1ns/1ps
module swc_cmd #(
  parameter int unsigned PRG_CYC_P   = swc_pkg::PRG_CYC,
  parameter int unsigned SPU_CYC_P   = swc_pkg::SPU_CYC,
  parameter int unsigned OTHER_CYC_P = swc_pkg::OTHER_CYC
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_n_i,
  input  wire swc_pkg::swc_byte_type    host_rx_i,
  output logic                          host_rx_ready_o,
  output swc_pkg::swc_byte_type         host_tx_o,
  input  wire logic                     host_tx_ready_i,
  output swc_pkg::swc_bus_req_type      bus_req_o,
  input  wire swc_pkg::swc_bus_rsp_type bus_rsp_i,
  output logic                          spu_o,
  output logic                          prg_o,
  output logic                          data_mode_o,
  output logic                          overrun_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam swc_pkg::swc_regs_type REGS_RST = '{
    st:       swc_pkg::SWC_ST_IDLE,
    buf_full: 1'b0, buf_data: 8'h00, cmd: 8'h00,
    data_mode: 1'b0, armed: 1'b0,
    prg_code: swc_pkg::DUR_RST, spu_code: swc_pkg::DUR_RST,
    pulse_on: 1'b0, pulse_prg: 1'b0, timer: 32'h0000_0000,
    tx: '0, bus: '0, ovr: 1'b0
  };

  function automatic logic [31:0] dur_cyc(input logic prg,
                                          input logic [2:0] code);
    if (code == swc_pkg::DUR_DOC) begin
      dur_cyc = prg ? 32'(PRG_CYC_P) : 32'(SPU_CYC_P);
    end else begin
      dur_cyc = 32'(OTHER_CYC_P);
    end
  endfunction

  function automatic logic [7:0] pulse_rsp(input logic prg);
    pulse_rsp = {swc_pkg::PULSE_TAG, prg, swc_pkg::RSP_PULSE_LO};
  endfunction

  swc_pkg::swc_regs_type s_r;
  swc_pkg::swc_regs_type s_nxt;
  logic                  take;
  logic                  term_seen;
  logic [7:0]            c;

  // only take a byte when the reply slot is free, so no reply is lost
  assign take      = (s_r.st == swc_pkg::SWC_ST_IDLE) && s_r.buf_full &&
                     !s_r.tx.valid;
  assign term_seen = (s_r.st == swc_pkg::SWC_ST_PINF) && s_r.buf_full &&
                     (s_r.buf_data == swc_pkg::CMD_TERM);
  assign c         = s_r.buf_data;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt           = s_r;
    s_nxt.bus.valid = 1'b0;
    s_nxt.ovr       = 1'b0;
    if (s_r.tx.valid && host_tx_ready_i) begin
      s_nxt.tx.valid = 1'b0;
    end
    // single-entry receive buffer
    if (host_rx_i.valid && !s_r.buf_full) begin
      s_nxt.buf_full = 1'b1;
      s_nxt.buf_data = host_rx_i.data;
    end else if (host_rx_i.valid) begin
      s_nxt.ovr = 1'b1;
    end
    unique case (s_r.st)
      swc_pkg::SWC_ST_IDLE: begin
        if (take) begin
          s_nxt.buf_full = 1'b0;
          s_nxt.cmd      = c;
          if (s_r.data_mode) begin
            if (c == swc_pkg::CMD_CMD_MODE) begin
              s_nxt.data_mode = 1'b0;
            end else begin
              // FF reads: slaves pull the released slots low
              s_nxt.bus = '{1'b1, swc_pkg::SWC_OP_BYTE, c};
              s_nxt.st  = swc_pkg::SWC_ST_BYTE;
            end
          end else if (c == swc_pkg::CMD_DATA_MODE) begin
            s_nxt.data_mode = 1'b1;
          end else if (c == swc_pkg::CMD_RESET) begin
            s_nxt.bus = '{1'b1, swc_pkg::SWC_OP_RESET, 8'h00};
            s_nxt.st  = swc_pkg::SWC_ST_RST;
          end else if (c[7:5] == swc_pkg::SB_TAG && c[0]) begin
            s_nxt.bus = '{1'b1, swc_pkg::SWC_OP_BIT,
                          {7'h00, c[swc_pkg::BIT_VAL]}};
            s_nxt.st  = swc_pkg::SWC_ST_BIT;
          end else if (c[7:5] == swc_pkg::PULSE_TAG && c[0] &&
                       c[3:2] == swc_pkg::PULSE_SUB) begin
            s_nxt.armed     = c[swc_pkg::BIT_SPU];
            s_nxt.pulse_on  = 1'b1;
            s_nxt.pulse_prg = c[swc_pkg::BIT_VAL];
            if ((c[swc_pkg::BIT_VAL] ? s_r.prg_code : s_r.spu_code) ==
                swc_pkg::DUR_INF) begin
              s_nxt.st = swc_pkg::SWC_ST_PINF;
            end else begin
              s_nxt.timer = dur_cyc(c[swc_pkg::BIT_VAL],
                c[swc_pkg::BIT_VAL] ? s_r.prg_code : s_r.spu_code);
              s_nxt.st    = swc_pkg::SWC_ST_PTIM;
            end
          end else if (!c[7] && c[0]) begin
            if (c[6:4] == swc_pkg::PAR_PRG) begin
              s_nxt.prg_code = c[3:1];
            end else if (c[6:4] == swc_pkg::PAR_SPU) begin
              s_nxt.spu_code = c[3:1];
            end
            s_nxt.tx = '{1'b1, {c[7:1], 1'b0}};
          end
          // a stray F1 or unknown byte here is dropped
        end
      end
      swc_pkg::SWC_ST_RST: begin
        if (bus_rsp_i.done) begin
          s_nxt.tx = '{1'b1, {swc_pkg::RSP_RESET_HI, bus_rsp_i.pres}};
          s_nxt.st = swc_pkg::SWC_ST_IDLE;
        end
      end
      swc_pkg::SWC_ST_BIT: begin
        if (bus_rsp_i.done) begin
          s_nxt.tx = '{1'b1, {s_r.cmd[7:2], bus_rsp_i.data[0],
                              bus_rsp_i.data[0]}};
          s_nxt.st = swc_pkg::SWC_ST_IDLE;
          if (s_r.cmd[swc_pkg::BIT_SPU]) begin
            s_nxt.pulse_on  = 1'b1;
            s_nxt.pulse_prg = 1'b0;
            if (s_r.spu_code == swc_pkg::DUR_INF) begin
              s_nxt.st = swc_pkg::SWC_ST_PINF;
            end else begin
              s_nxt.timer = dur_cyc(1'b0, s_r.spu_code);
              s_nxt.st    = swc_pkg::SWC_ST_PTIM;
            end
          end
        end
      end
      swc_pkg::SWC_ST_BYTE: begin
        if (bus_rsp_i.done) begin
          s_nxt.tx = '{1'b1, bus_rsp_i.data};
          s_nxt.st = swc_pkg::SWC_ST_IDLE;
          if (s_r.armed) begin
            s_nxt.pulse_on  = 1'b1;
            s_nxt.pulse_prg = 1'b0;
            // data mode stays set, but an F1 terminator still ends an infinite pullup here
            if (s_r.spu_code == swc_pkg::DUR_INF) begin
              s_nxt.st = swc_pkg::SWC_ST_PINF;
            end else begin
              s_nxt.timer = dur_cyc(1'b0, s_r.spu_code);
              s_nxt.st    = swc_pkg::SWC_ST_PTIM;
            end
          end
        end
      end
      swc_pkg::SWC_ST_PTIM: begin
        if (s_r.timer > 32'h0000_0001) begin
          s_nxt.timer = s_r.timer - 32'h0000_0001;
        end else begin
          s_nxt.pulse_on = 1'b0;
          s_nxt.st       = swc_pkg::SWC_ST_PRSP;
        end
      end
      swc_pkg::SWC_ST_PINF: begin
        // the host only sends F1 after reading the bit reply, so the
        // shortest pullup is two character times
        if (s_r.buf_full) begin
          s_nxt.buf_full = 1'b0;
          if (term_seen) begin
            s_nxt.pulse_on = 1'b0;
            s_nxt.st       = swc_pkg::SWC_ST_PRSP;
          end
        end
      end
      swc_pkg::SWC_ST_PRSP: begin
        if (!s_r.tx.valid) begin
          s_nxt.tx = '{1'b1, pulse_rsp(s_r.pulse_prg)};
          s_nxt.st = swc_pkg::SWC_ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = swc_pkg::SWC_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= REGS_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign host_rx_ready_o = !s_r.buf_full;
  assign host_tx_o       = s_r.tx;
  assign bus_req_o       = s_r.bus;
  assign spu_o           = s_r.pulse_on && !s_r.pulse_prg;
  assign prg_o           = s_r.pulse_on && s_r.pulse_prg;
  assign data_mode_o     = s_r.data_mode;
  assign overrun_o       = s_r.ovr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_sb_inf_on;
    (s_r.st == swc_pkg::SWC_ST_BIT) && bus_rsp_i.done &&
    s_r.cmd[swc_pkg::BIT_SPU] && (s_r.spu_code == swc_pkg::DUR_INF)
    |=> spu_o && (s_r.st == swc_pkg::SWC_ST_PINF);
  endproperty
  a_sb_inf_on: assert property (p_sb_inf_on)
    else $error("infinite pullup not started after slot");

  property p_inf_hold;
    (s_r.st == swc_pkg::SWC_ST_PINF) && !term_seen
    |=> (s_r.st == swc_pkg::SWC_ST_PINF) && $stable(s_r.pulse_on);
  endproperty
  a_inf_hold: assert property (p_inf_hold)
    else $error("infinite pullup left without terminator");

  property p_term_end;
    term_seen |=> !s_r.pulse_on ##[0:3]
      (s_r.tx.valid && s_r.tx.data == pulse_rsp(s_r.pulse_prg));
  endproperty
  a_term_end: assert property (p_term_end)
    else $error("terminator did not end pulse and reply");

  property p_rx_buf;
    host_rx_i.valid && !s_r.buf_full
    |=> s_r.buf_full && (s_r.buf_data == $past(host_rx_i.data));
  endproperty
  a_rx_buf: assert property (p_rx_buf)
    else $error("host byte not held in buffer");

  property p_reset_rsp;
    (s_r.st == swc_pkg::SWC_ST_RST) && bus_rsp_i.done &&
    (bus_rsp_i.pres == swc_pkg::PRES_OK)
    |=> s_r.tx.valid && (s_r.tx.data == 8'hCD);
  endproperty
  a_reset_rsp: assert property (p_reset_rsp)
    else $error("reset reply wrong");

  property p_data_echo;
    (s_r.st == swc_pkg::SWC_ST_BYTE) && bus_rsp_i.done
    |=> s_r.tx.valid && (s_r.tx.data == $past(bus_rsp_i.data));
  endproperty
  a_data_echo: assert property (p_data_echo)
    else $error("data byte reply differs from sampled byte");

  property p_cfg_prg;
    take && !s_r.data_mode && (c == 8'h29)
    |=> (s_r.prg_code == swc_pkg::DUR_DOC) && (s_r.tx.data == 8'h28);
  endproperty
  a_cfg_prg: assert property (p_cfg_prg)
    else $error("programming duration config failed");

  property p_cfg_spu;
    take && !s_r.data_mode && (c == 8'h39)
    |=> (s_r.spu_code == swc_pkg::DUR_DOC) && (s_r.tx.data == 8'h38);
  endproperty
  a_cfg_spu: assert property (p_cfg_spu)
    else $error("pullup duration config failed");

  property p_armed;
    (s_r.st == swc_pkg::SWC_ST_BYTE) && bus_rsp_i.done && s_r.armed
    |=> spu_o && s_r.tx.valid;
  endproperty
  a_armed: assert property (p_armed)
    else $error("armed pullup missing after data byte");

  property p_sb_timed;
    (s_r.st == swc_pkg::SWC_ST_BIT) && bus_rsp_i.done &&
    s_r.cmd[swc_pkg::BIT_SPU] && (s_r.spu_code != swc_pkg::DUR_INF)
    |=> s_r.tx.valid && spu_o && (s_r.st == swc_pkg::SWC_ST_PTIM);
  endproperty
  a_sb_timed: assert property (p_sb_timed)
    else $error("timed single bit pullup reply missing");

endmodule // swc_cmd

// *** verif/swc_bus_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// bus engine with slaves behind it
// ----------------------------------------------------------------
module swc_bus_model (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_n_i,
  input  wire swc_pkg::swc_bus_req_type bus_req_i,
  input  wire logic [3:0]               dly_i,
  input  wire logic [7:0]               pull_i,
  input  wire logic [1:0]               pres_i,
  output swc_pkg::swc_bus_rsp_type      bus_rsp_o
);
  logic       busy_r;
  logic [3:0] cnt_r;

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      bus_rsp_o <= '0;
    end else begin
      // stale result toggles so it never passes for a fresh one
      bus_rsp_o.done <= 1'b0;
      bus_rsp_o.data <= ~bus_rsp_o.data;
      bus_rsp_o.pres <= ~bus_rsp_o.pres;
      if (bus_req_i.valid) begin
        busy_r <= 1'b1;
        cnt_r <= dly_i;
      end else if (busy_r && cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end else if (busy_r) begin
        busy_r <= 1'b0;
        bus_rsp_o.done <= 1'b1;
        // slaves can only pull slots low, never drive them high
        bus_rsp_o.data <= bus_req_i.data & ~pull_i;
        bus_rsp_o.pres <= pres_i;
      end
    end
  end
endmodule // swc_bus_model

// *** verif/swc_cmd_test.sv ***
`timescale 1ns/1ps
module swc_cmd_test;
  logic                     ref_clk_i;
  logic                     rst_n_i;
  swc_pkg::swc_byte_type    rx;
  logic                     rx_rdy;
  swc_pkg::swc_byte_type    tx;
  logic                     tx_rdy;
  swc_pkg::swc_bus_req_type req;
  swc_pkg::swc_bus_rsp_type rsp;
  logic                     spu, prg, dmode, ovr;
  logic [3:0]               dly;
  logic [1:0]               pres;
  logic [7:0]               pull, b;
  logic [7:0]               exp_q[$];
  int                       seed = 32'h99d4;
  int                       failures = 0;
  int                       n_compared = 0;

  swc_cmd #(.PRG_CYC_P(20), .SPU_CYC_P(30), .OTHER_CYC_P(40)) dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .host_rx_i(rx),
    .host_rx_ready_o(rx_rdy), .host_tx_o(tx), .host_tx_ready_i(tx_rdy),
    .bus_req_o(req), .bus_rsp_i(rsp), .spu_o(spu), .prg_o(prg),
    .data_mode_o(dmode), .overrun_o(ovr));

  swc_bus_model bus (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_req_i(req),
    .dly_i(dly), .pull_i(pull), .pres_i(pres), .bus_rsp_o(rsp));

  // ----------------------------------------------------------------
  // clock, host stalls, reply watcher
  // ----------------------------------------------------------------
  always #5 ref_clk_i = ~ref_clk_i;

  // host receiver stalls at random to stretch reply holding
  always @(posedge ref_clk_i) #1 tx_rdy = ($random(seed) % 3) != 0;

  always @(posedge ref_clk_i) begin
    if (tx.valid === 1'b1 && tx_rdy) begin
      // an empty queue means a reply nobody asked for
      if (exp_q.size() == 0) check("extra reply", tx.data, 8'hxx);
      else check("reply", tx.data, exp_q.pop_front());
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic give_up();
    failures++;
    results();
  endtask

  task automatic send(logic [7:0] d);
    int k;
    k = 0;
    @(posedge ref_clk_i);
    #1;
    while (rx_rdy !== 1'b1) begin
      @(posedge ref_clk_i);
      #1;
      k++;
      if (k > 3000) give_up();
    end
    rx.valid = 1'b1;
    rx.data = d;
    @(posedge ref_clk_i);
    #1;
    rx.valid = 1'b0;
  endtask

  // wait until at most n replies are still owed
  task automatic drain(int n);
    int k;
    k = 0;
    while (exp_q.size() > n) begin
      @(posedge ref_clk_i);
      #1;
      k++;
      if (k > 3000) give_up();
    end
  endtask

  task automatic xfer(logic [7:0] d, logic [7:0] r);
    exp_q.push_back(r);
    send(d);
    drain(0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    rst_n_i = 1'b0;
    rx = '0;
    tx_rdy = 1'b1;
    dly = 4'h2;
    pull = 8'h00;
    pres = 2'h1;
    repeat (8) @(posedge ref_clk_i);
    #1;
    rst_n_i = 1'b1;
    check("ready after reset", {7'h0, rx_rdy}, 8'h01);
    xfer(8'hC1, 8'hCD);
    // other presence codes pass straight into the reset reply
    pres = 2'($random(seed));
    xfer(8'hC1, {swc_pkg::RSP_RESET_HI, pres});
    pres = 2'h1;
    xfer(8'h29, 8'h28);
    xfer(8'h39, 8'h38);
    send(8'hE1);
    for (int i = 0; i < 8; i++) begin
      b = 8'($random(seed));
      dly = 4'($random(seed));
      if (b == swc_pkg::CMD_CMD_MODE) b = 8'h33;
      if (i[0]) b = swc_pkg::CMD_READ;
      pull = i[0] ? 8'($random(seed)) : 8'h00;
      xfer(b, b & ~pull);
    end
    check("data mode", {7'h0, dmode}, 8'h01);
    pull = 8'h00;
    send(8'hE3);
    // timed pullup after a single slot
    exp_q.push_back(8'h93);
    exp_q.push_back(8'hEC);
    send(8'h93);
    drain(1);
    check("timed spu", {7'h0, spu}, 8'h01);
    drain(0);
    check("timed spu end", {7'h0, spu}, 8'h00);
    check("cmd mode", {7'h0, dmode}, 8'h00);
    // infinite pullup: only the termination byte ends it
    xfer(8'h3F, 8'h3E);
    xfer(8'h93, 8'h93);
    check("inf spu", {7'h0, spu}, 8'h01);
    send(8'h33);
    repeat (40) @(posedge ref_clk_i);
    #1;
    check("inf spu held", {7'h0, spu}, 8'h01);
    exp_q.push_back(8'hEC);
    send(swc_pkg::CMD_TERM);
    repeat (2) @(posedge ref_clk_i);
    #1;
    check("inf spu off", {7'h0, spu}, 8'h00);
    drain(0);
    xfer(8'h39, 8'h38);
    // armed pullup after a data byte
    xfer(8'hEF, 8'hEC);
    send(8'hE1);
    exp_q.push_back(8'h44);
    exp_q.push_back(8'hEC);
    send(8'h44);
    drain(1);
    check("armed spu", {7'h0, spu}, 8'h01);
    drain(0);
    send(8'hE3);
    xfer(8'hED, 8'hEC);
    // an undocumented spu code falls back to the generic length
    xfer(8'h31, 8'h30);
    exp_q.push_back(8'hEC);
    send(8'hED);
    repeat (36) @(posedge ref_clk_i);
    #1;
    check("generic spu", {7'h0, spu}, 8'h01);
    drain(0);
    check("generic spu end", {7'h0, spu}, 8'h00);
    // programming pulse of the configured length
    exp_q.push_back(8'hFC);
    send(8'hFD);
    repeat (2) @(posedge ref_clk_i);
    #1;
    check("prg on", {7'h0, prg}, 8'h01);
    repeat (15) @(posedge ref_clk_i);
    #1;
    check("prg held", {7'h0, prg}, 8'h01);
    drain(0);
    check("prg off", {7'h0, prg}, 8'h00);
    // one byte buffered behind a slow bus op, a third one dropped
    dly = 4'hF;
    exp_q.push_back(8'hCD);
    exp_q.push_back(8'hCD);
    send(8'hC1);
    send(8'hC1);
    check("buffer full", {7'h0, rx_rdy}, 8'h00);
    @(posedge ref_clk_i);
    #1;
    rx.valid = 1'b1;
    rx.data = 8'hC1;
    @(posedge ref_clk_i);
    #1;
    rx.valid = 1'b0;
    check("overrun", {7'h0, ovr}, 8'h01);
    drain(0);
    repeat (60) @(posedge ref_clk_i);
    results();
  end
endmodule // swc_cmd_test
